/* File: rtl/tcs_channel_status.sv */
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module tcs_channel_status
    import tcs_pkg::*;
#(
    parameter int WB_PERIOD = WB_PERIOD_CYC,
    parameter int WB_TEST   = WB_TEST_CYC
) (
    input  wire logic                       CLK_SYS_I,
    input  wire logic                       RST_I,
    input  wire logic                       CE_I,
    input  wire logic [AW-1:0]              ADDR_I,
    input  wire logic [DW-1:0]              WDATA_I,
    input  wire logic                       WR_I,
    input  wire logic                       RD_I,
    output logic      [DW-1:0]              RDATA_O,
    input  wire logic                       FB_RESTART_I,
    input  wire logic [N_CH-1:0]            MEAS_VALID_I,
    input  wire logic [N_CH-1:0][15:0]      MEAS_VALUE_I,
    input  wire logic [N_CH-1:0]            MEAS_BELOW_I,
    input  wire logic [N_CH-1:0]            MEAS_ABOVE_I,
    input  wire logic [N_CH-1:0]            WIRE_OPEN_I,
    input  wire logic [N_CH-1:0][15:0]      CJ_INTERNAL_I,
    output logic      [N_CH-1:0]            TEST_CURRENT_O,
    output logic      [N_CH-1:0]            SAMPLE_SUSPEND_O,
    output logic      [N_CH-1:0][15:0]      CJ_REF_O,
    output logic                            IRQ_O
);
    tcs_state_t st_reg;
    tcs_state_t st_next;

    always_comb begin
        logic [7:0]  ev;
        logic [7:0]  clr;
        logic        upd;
        logic        err_old;
        logic        err_new;
        logic [3:0]  sel;
        logic [7:0]  base;
        st_next = st_reg;
        ev      = 8'h00;
        clr     = 8'h00;
        upd     = 1'b0;
        err_old = 1'b0;
        err_new = 1'b0;
        sel     = 4'h0;
        base    = 8'h00;
        // Shared wire-break timer
        if (st_reg.testing) begin
            if (st_reg.wb_cnt >= 32'(WB_TEST - 1)) begin
                st_next.testing = 1'b0;
                st_next.wb_cnt  = 32'h00000000;
            end else begin
                st_next.wb_cnt = st_reg.wb_cnt + 32'h00000001;
            end
        end else if (st_reg.wb_cnt >= 32'(WB_PERIOD - 1)) begin
            st_next.testing = 1'b1;
            st_next.wb_cnt  = 32'h00000000;
        end else begin
            st_next.wb_cnt = st_reg.wb_cnt + 32'h00000001;
        end
        if (FB_RESTART_I) begin
            st_next.set_act = st_reg.set_sel;
        end
        for (int i = 0; i < N_CH; i++) begin
            err_old = st_reg.ch[i].below | st_reg.ch[i].above | st_reg.ch[i].broken;
            if (st_reg.ch[i].cfg.wb_disable) begin
                st_next.ch[i].broken = 1'b0;
            end else if (st_reg.testing && st_reg.wb_cnt == 32'(WB_TEST - 1)) begin
                st_next.ch[i].broken = WIRE_OPEN_I[i];
            end
            upd = MEAS_VALID_I[i] && st_reg.set_act[i] && !SAMPLE_SUSPEND_O[i];
            if (upd) begin
                st_next.ch[i].value  = MEAS_VALUE_I[i];
                st_next.ch[i].below  = MEAS_BELOW_I[i];
                st_next.ch[i].above  = MEAS_ABOVE_I[i];
                st_next.ch[i].lim1   = tcs_limit(st_reg.ch[i].cfg.lim1_en, MEAS_VALUE_I[i],
                                                 st_reg.ch[i].lim1_val);
                st_next.ch[i].lim2   = tcs_limit(st_reg.ch[i].cfg.lim2_en, MEAS_VALUE_I[i],
                                                 st_reg.ch[i].lim2_val);
                st_next.ch[i].toggle = ~st_reg.ch[i].toggle;
            end
            if (st_reg.ch[i].cfg.cj_src == CJ_EXTERNAL) begin
                st_next.ch[i].cj_ref = st_reg.ch[i].ext_ref;
            end else begin
                st_next.ch[i].cj_ref = CJ_INTERNAL_I[i];
            end
            err_new = st_next.ch[i].below | st_next.ch[i].above | st_next.ch[i].broken;
            ev[i]             = err_new & ~err_old;
            ev[IRQ_BREAK + i] = st_next.ch[i].broken & ~st_reg.ch[i].broken;
        end
        // Register writes
        if (WR_I) begin
            case (ADDR_I)
                A_IRQ_ENABLE: st_next.irq_enable = WDATA_I[7:0];
                A_IRQ_CLEAR:  clr                = WDATA_I[7:0];
                A_SET_SELECT: st_next.set_sel    = WDATA_I[N_CH-1:0];
                default: begin
                    for (int i = 0; i < N_CH; i++) begin
                        base = A_CH_BASE + 8'(i) * A_CH_STRIDE;
                        if (ADDR_I == base + 8'(O_CH_CONFIG)) begin
                            st_next.ch[i].cfg.wb_disable = WDATA_I[CFG_WB_DIS];
                            st_next.ch[i].cfg.cj_src     = WDATA_I[CFG_CJ_LO +: 2];
                            st_next.ch[i].cfg.lim1_en    = WDATA_I[CFG_LIM1_EN];
                            st_next.ch[i].cfg.lim2_en    = WDATA_I[CFG_LIM2_EN];
                        end
                        if (ADDR_I == base + 8'(O_CH_LIMITS)) begin
                            st_next.ch[i].lim1_val = WDATA_I[15:0];
                            st_next.ch[i].lim2_val = WDATA_I[31:16];
                        end
                        if (ADDR_I == base + 8'(O_CH_EXT_REF)) begin
                            st_next.ch[i].ext_ref = WDATA_I[15:0];
                        end
                    end
                end
            endcase
        end
        // Set wins over clear
        st_next.irq_status = (st_reg.irq_status & ~clr) | ev;
        if (RD_I) begin
            st_next.rdata = 32'h00000000;
            case (ADDR_I)
                A_IRQ_STATUS: st_next.rdata[7:0]      = st_reg.irq_status;
                A_IRQ_ENABLE: st_next.rdata[7:0]      = st_reg.irq_enable;
                A_SET_SELECT: st_next.rdata[N_CH-1:0] = st_reg.set_sel;
                A_SET_ACTIVE: st_next.rdata[N_CH-1:0] = st_reg.set_act;
                default: begin
                    for (int i = 0; i < N_CH; i++) begin
                        base = A_CH_BASE + 8'(i) * A_CH_STRIDE;
                        if (ADDR_I == base + 8'(O_CH_CONFIG)) begin
                            st_next.rdata[CFG_WB_DIS]    = st_reg.ch[i].cfg.wb_disable;
                            st_next.rdata[CFG_CJ_LO +: 2] = st_reg.ch[i].cfg.cj_src;
                            st_next.rdata[CFG_LIM1_EN]   = st_reg.ch[i].cfg.lim1_en;
                            st_next.rdata[CFG_LIM2_EN]   = st_reg.ch[i].cfg.lim2_en;
                        end
                        if (ADDR_I == base + 8'(O_CH_LIMITS)) begin
                            st_next.rdata = {st_reg.ch[i].lim2_val, st_reg.ch[i].lim1_val};
                        end
                        if (ADDR_I == base + 8'(O_CH_EXT_REF)) begin
                            st_next.rdata[15:0] = st_reg.ch[i].ext_ref;
                        end
                        if (ADDR_I == base + 8'(O_CH_PROCESS) && st_reg.set_act[i]) begin
                            st_next.rdata = {st_reg.ch[i].value, tcs_status_word(st_reg.ch[i])};
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            st_reg         <= '0;
            st_reg.set_sel <= SET_RESET;
            st_reg.set_act <= SET_RESET;
        end else if (CE_I) begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        for (int i = 0; i < N_CH; i++) begin
            TEST_CURRENT_O[i]   = st_reg.testing & ~st_reg.ch[i].cfg.wb_disable;
            SAMPLE_SUSPEND_O[i] = st_reg.testing & ~st_reg.ch[i].cfg.wb_disable;
            CJ_REF_O[i]         = st_reg.ch[i].cj_ref;
        end
    end

    assign RDATA_O = st_reg.rdata;
    assign IRQ_O   = |(st_reg.irq_status & st_reg.irq_enable);

    // Status words of the checked channels
    logic [15:0] sw0;
    logic [15:0] sw1;
    logic [15:0] sw2;
    assign sw0 = tcs_status_word(st_reg.ch[0]);
    assign sw1 = tcs_status_word(st_reg.ch[1]);
    assign sw2 = tcs_status_word(st_reg.ch[2]);

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    sequence s_update0;
        CE_I && MEAS_VALID_I[0] && st_reg.set_act[0] && !SAMPLE_SUSPEND_O[0];
    endsequence

    sequence s_update1;
        CE_I && MEAS_VALID_I[1] && st_reg.set_act[1] && !SAMPLE_SUSPEND_O[1];
    endsequence

    property p_below;
        s_update1 ##0 MEAS_BELOW_I[1] |=> st_reg.ch[1].below && sw1[SW_BELOW];
    endproperty
    a_below: assert property (p_below) else $error("below flag not set");

    property p_broken;
        st_reg.ch[2].broken |-> sw2[SW_ABOVE] && sw2[SW_ERROR];
    endproperty
    a_broken: assert property (p_broken) else $error("break not shown as above plus error");

    property p_lim1;
        s_update0 ##0 (st_reg.ch[0].cfg.lim1_en && $signed(MEAS_VALUE_I[0]) > $signed(st_reg.ch[0].lim1_val))
            |=> sw0[SW_LIM1 +: 2] == LIM_OVER;
    endproperty
    a_lim1: assert property (p_lim1) else $error("limit 1 overshoot not coded 1");

    property p_error;
        sw1[SW_ERROR] == (st_reg.ch[1].below | st_reg.ch[1].above | st_reg.ch[1].broken);
    endproperty
    a_error: assert property (p_error) else $error("error flag mismatch");

    property p_invalid;
        sw1[SW_INVALID] == sw1[SW_ERROR];
    endproperty
    a_invalid: assert property (p_invalid) else $error("validity flag mismatch");

    property p_toggle;
        s_update0 |=> st_reg.ch[0].toggle != $past(st_reg.ch[0].toggle);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle did not invert");

    sequence s_test_start;
        $rose(TEST_CURRENT_O[2]);
    endsequence

    property p_test;
        s_test_start |-> SAMPLE_SUSPEND_O[2] && st_reg.wb_cnt == 32'h00000000;
    endproperty
    a_test: assert property (p_test) else $error("test current without suspend");

    property p_wb_dis;
        st_reg.ch[0].cfg.wb_disable |-> !TEST_CURRENT_O[0] ##1 (!st_reg.ch[0].broken || !$past(CE_I));
    endproperty
    a_wb_dis: assert property (p_wb_dis) else $error("disabled detection still active");

    property p_restart;
        !(CE_I && FB_RESTART_I) |=> $stable(st_reg.set_act);
    endproperty
    a_restart: assert property (p_restart) else $error("set selection applied without restart");

    property p_cj;
        CE_I && st_reg.ch[3].cfg.cj_src == CJ_EXTERNAL |=> CJ_REF_O[3] == $past(st_reg.ch[3].ext_ref);
    endproperty
    a_cj: assert property (p_cj) else $error("external reference not used");

    property p_suspend;
        CE_I && SAMPLE_SUSPEND_O[2] |=> $stable(st_reg.ch[2].toggle) && $stable(st_reg.ch[2].value);
    endproperty
    a_suspend: assert property (p_suspend) else $error("sample taken during test");

    property p_break_latch;
        CE_I && st_reg.testing && st_reg.wb_cnt == 32'(WB_TEST - 1) && !st_reg.ch[2].cfg.wb_disable
            |=> st_reg.ch[2].broken == $past(WIRE_OPEN_I[2]);
    endproperty
    a_break_latch: assert property (p_break_latch) else $error("break not latched at test end");

    property p_value;
        s_update0 |=> st_reg.ch[0].value == $past(MEAS_VALUE_I[0]);
    endproperty
    a_value: assert property (p_value) else $error("result not captured");

    property p_above;
        s_update1 ##0 MEAS_ABOVE_I[1] |=> st_reg.ch[1].above && sw1[SW_ABOVE] && sw1[SW_ERROR];
    endproperty
    a_above: assert property (p_above) else $error("above flag not set");

    property p_lim1_under;
        s_update0 ##0 (st_reg.ch[0].cfg.lim1_en && $signed(MEAS_VALUE_I[0]) < $signed(st_reg.ch[0].lim1_val))
            |=> sw0[SW_LIM1 +: 2] == LIM_UNDER;
    endproperty
    a_lim1_under: assert property (p_lim1_under) else $error("limit 1 undershoot not coded 2");

    property p_lim2_under;
        s_update0 ##0 (st_reg.ch[0].cfg.lim2_en && $signed(MEAS_VALUE_I[0]) < $signed(st_reg.ch[0].lim2_val))
            |=> sw0[SW_LIM2 +: 2] == LIM_UNDER;
    endproperty
    a_lim2_under: assert property (p_lim2_under) else $error("limit 2 undershoot not coded 2");

    property p_inactive;
        CE_I && !st_reg.set_act[0] |=> $stable(st_reg.ch[0].toggle);
    endproperty
    a_inactive: assert property (p_inactive) else $error("inactive set updated");

    property p_read_off;
        CE_I && RD_I && ADDR_I == A_CH_BASE + 8'(O_CH_PROCESS) && !st_reg.set_act[0]
            |=> RDATA_O == 32'h00000000;
    endproperty
    a_read_off: assert property (p_read_off) else $error("inactive set not omitted");

    property p_apply;
        CE_I && FB_RESTART_I |=> st_reg.set_act == $past(st_reg.set_sel);
    endproperty
    a_apply: assert property (p_apply) else $error("selection not applied on restart");

    property p_layout;
        CE_I && RD_I && ADDR_I == A_CH_BASE + 8'(O_CH_PROCESS) && st_reg.set_act[0]
            |=> RDATA_O[31:16] == $past(st_reg.ch[0].value) && RDATA_O[SW_BELOW] == $past(st_reg.ch[0].below)
                && RDATA_O[SW_LIM1 +: 2] == $past(st_reg.ch[0].lim1)
                && RDATA_O[SW_TOGGLE] == $past(st_reg.ch[0].toggle);
    endproperty
    a_layout: assert property (p_layout) else $error("process word layout wrong");
endmodule : tcs_channel_status

/* File: rtl/tcs_pkg.sv */
package tcs_pkg;
    localparam int          N_CH          = 4;
    localparam int          AW            = 8;
    localparam int          DW            = 32;
    localparam int          CLK_MHZ       = 40;
    // Wire-break test timing
    localparam int          WB_PERIOD_US  = 100000;
    localparam int          WB_TEST_US    = 1000;
    localparam int          WB_PERIOD_CYC = WB_PERIOD_US * CLK_MHZ;
    localparam int          WB_TEST_CYC   = WB_TEST_US * CLK_MHZ;
    // Register map
    localparam logic [7:0]  A_IRQ_STATUS  = 8'h00;
    localparam logic [7:0]  A_IRQ_ENABLE  = 8'h04;
    localparam logic [7:0]  A_IRQ_CLEAR   = 8'h08;
    localparam logic [7:0]  A_SET_SELECT  = 8'h0C;
    localparam logic [7:0]  A_SET_ACTIVE  = 8'h10;
    localparam logic [7:0]  A_CH_BASE     = 8'h40;
    localparam logic [7:0]  A_CH_STRIDE   = 8'h10;
    localparam logic [3:0]  O_CH_CONFIG   = 4'h0;
    localparam logic [3:0]  O_CH_LIMITS   = 4'h4;
    localparam logic [3:0]  O_CH_EXT_REF  = 4'h8;
    localparam logic [3:0]  O_CH_PROCESS  = 4'hC;
    // Config fields
    localparam int          CFG_WB_DIS    = 0;
    localparam int          CFG_CJ_LO     = 1;
    localparam int          CFG_LIM1_EN   = 3;
    localparam int          CFG_LIM2_EN   = 4;
    localparam logic [1:0]  CJ_EXTERNAL   = 2'h2;
    // Limit encodings
    localparam logic [1:0]  LIM_OK        = 2'h0;
    localparam logic [1:0]  LIM_OVER      = 2'h1;
    localparam logic [1:0]  LIM_UNDER     = 2'h2;
    // Status word positions, break interrupt offset and set reset value
    localparam int          SW_BELOW      = 0;
    localparam int          SW_ABOVE      = 1;
    localparam int          SW_LIM1       = 2;
    localparam int          SW_LIM2       = 4;
    localparam int          SW_ERROR      = 6;
    localparam int          SW_INVALID    = 14;
    localparam int          SW_TOGGLE     = 15;
    localparam int          IRQ_BREAK     = 4;
    localparam logic [3:0]  SET_RESET     = 4'hF;

    typedef struct packed {
        logic        wb_disable;
        logic [1:0]  cj_src;
        logic        lim1_en;
        logic        lim2_en;
    } tcs_cfg_t;

    typedef struct packed {
        tcs_cfg_t    cfg;
        logic [15:0] lim1_val;
        logic [15:0] lim2_val;
        logic [15:0] ext_ref;
        logic [15:0] cj_ref;
        logic [15:0] value;
        logic        below;
        logic        above;
        logic        broken;
        logic [1:0]  lim1;
        logic [1:0]  lim2;
        logic        toggle;
    } tcs_ch_t;

    typedef struct packed {
        tcs_ch_t [N_CH-1:0] ch;
        logic [31:0]        wb_cnt;
        logic               testing;
        logic [7:0]         irq_status;
        logic [7:0]         irq_enable;
        logic [N_CH-1:0]    set_sel;
        logic [N_CH-1:0]    set_act;
        logic [DW-1:0]      rdata;
    } tcs_state_t;

    function automatic logic [15:0] tcs_status_word(input tcs_ch_t c);
        logic [15:0] sw;
        logic        err;
        sw                       = 16'h0000;
        err                      = c.below | c.above | c.broken;
        sw[SW_BELOW]             = c.below;
        sw[SW_ABOVE]             = c.above | c.broken;
        sw[SW_LIM1 +: 2]         = c.lim1;
        sw[SW_LIM2 +: 2]         = c.lim2;
        sw[SW_ERROR]             = err;
        sw[SW_INVALID]           = err;
        sw[SW_TOGGLE]            = c.toggle;
        return sw;
    endfunction : tcs_status_word

    function automatic logic [1:0] tcs_limit(input logic en, input logic [15:0] v, input logic [15:0] lim);
        if (!en)
            return LIM_OK;
        if ($signed(v) > $signed(lim))
            return LIM_OVER;
        if ($signed(v) < $signed(lim))
            return LIM_UNDER;
        return LIM_OK;
    endfunction : tcs_limit
endpackage : tcs_pkg

/* File: testbench/tb_tcs_channel_status.sv */
`timescale 1ns/100ps
module tb_tcs_channel_status
    import tcs_pkg::*;
;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    logic [AW-1:0]         addr;
    logic [DW-1:0]         wdata;
    logic [DW-1:0]         rdata;
    logic                  wr;
    logic                  rd;
    logic                  restart = 1'b0;
    logic                  ce = 1'b1;
    logic [N_CH-1:0]       m_valid = '0;
    logic [N_CH-1:0][15:0] m_value = '0;
    logic [N_CH-1:0]       m_below = '0;
    logic [N_CH-1:0]       m_above = '0;
    logic [N_CH-1:0]       wire_open = '0;
    logic [N_CH-1:0][15:0] cj_int = {4{16'h0123}};
    logic [N_CH-1:0]       test_cur;
    logic [N_CH-1:0]       suspend;
    logic [N_CH-1:0][15:0] cj_ref;
    logic                  irq;
    int                    mismatches = 0;
    int                    comparisons = 0;
    int                    cycles = 0;

    always #12.5 clk = ~clk;

    tcs_channel_status #(.WB_PERIOD(20), .WB_TEST(5)) tcs_channel_status_inst (
        .CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .FB_RESTART_I(restart), .MEAS_VALID_I(m_valid), .MEAS_VALUE_I(m_value),
        .MEAS_BELOW_I(m_below), .MEAS_ABOVE_I(m_above), .WIRE_OPEN_I(wire_open), .CJ_INTERNAL_I(cj_int),
        .TEST_CURRENT_O(test_cur), .SAMPLE_SUSPEND_O(suspend), .CJ_REF_O(cj_ref), .IRQ_O(irq));

    tcs_fb_master_model tcs_fb_master_model_inst (
        .clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

    task automatic finish_test;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        cycles++;
        if (cycles >= 5000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        tcs_fb_master_model_inst.wr_reg(a, d);
    endtask : wrr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        tcs_fb_master_model_inst.rd_reg(a, d);
        chk(d, exp);
    endtask : rdc

    function automatic logic [7:0] ca(input int ch, input logic [3:0] off);
        return tcs_fb_master_model_inst.ch_addr(ch, off);
    endfunction : ca

    task automatic meas(input int ch, input logic [15:0] v, input logic b, input logic a);
        @(posedge clk);
        m_valid[ch] <= 1'b1;
        m_value[ch] <= v;
        m_below[ch] <= b;
        m_above[ch] <= a;
        @(posedge clk);
        m_valid[ch] <= 1'b0;
    endtask : meas

    task automatic pulse_restart;
        @(posedge clk);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
    endtask : pulse_restart

    task automatic t_reset;
        rdc(A_SET_ACTIVE, 32'h0000_000F);
        rdc(A_SET_SELECT, 32'h0000_000F);
        rdc(A_IRQ_STATUS, 32'h0000_0000);
        rdc(8'hFC, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_limits;
        wrr(ca(0, O_CH_CONFIG), 32'h0000_0019);
        wrr(ca(0, O_CH_LIMITS), {16'hFF9C, 16'd300});
        meas(0, 16'd500, 1'b0, 1'b0);
        rdc(ca(0, O_CH_PROCESS), {16'd500, 16'h8014});
        meas(0, 16'hFF38, 1'b0, 1'b0);
        rdc(ca(0, O_CH_PROCESS), {16'hFF38, 16'h0028});
        meas(0, 16'd300, 1'b0, 1'b0);
        rdc(ca(0, O_CH_PROCESS), {16'd300, 16'h8010});
        $display("test limits done");
    endtask : t_limits

    task automatic t_range;
        wrr(ca(1, O_CH_CONFIG), 32'h0000_0001);
        meas(1, 16'h8000, 1'b1, 1'b0);
        rdc(ca(1, O_CH_PROCESS), {16'h8000, 16'hC041});
        rdc(A_IRQ_STATUS, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0);
        wrr(A_IRQ_ENABLE, 32'h0000_0002);
        #1 chk({31'h0, irq}, 32'h1);
        meas(1, 16'h7FFF, 1'b0, 1'b1);
        rdc(ca(1, O_CH_PROCESS), {16'h7FFF, 16'h4042});
        wrr(A_IRQ_CLEAR, 32'h0000_0002);
        #1 chk({31'h0, irq}, 32'h0);
        meas(1, 16'd100, 1'b0, 1'b0);
        rdc(ca(1, O_CH_PROCESS), {16'd100, 16'h8000});
        $display("test range done");
    endtask : t_range

    task automatic t_wire_break;
        int n;
        wire_open[2] <= 1'b1;
        for (n = 0; n < 40 && test_cur[2] !== 1'b0; n++) @(posedge clk) #1;
        for (n = 0; n < 40 && test_cur[2] !== 1'b1; n++) @(posedge clk) #1;
        m_valid[2] <= 1'b1;
        for (n = 0; n < 40 && test_cur[2] === 1'b1; n++) begin
            chk({30'h0, suspend[2], test_cur[1:0]}, 32'h4);
            @(posedge clk) #1;
        end
        m_valid[2] <= 1'b0;
        chk(n, 5);
        rdc(ca(2, O_CH_PROCESS), {16'h0000, 16'h4042});
        rdc(A_IRQ_STATUS, 32'h0000_0044);
        wrr(ca(2, O_CH_CONFIG), 32'h0000_0001);
        for (n = 0; n < 45; n++) begin
            @(posedge clk) #1;
            chk({31'h0, test_cur[2]}, 32'h0);
        end
        rdc(ca(2, O_CH_PROCESS), 32'h0000_0000);
        $display("test wire break done");
    endtask : t_wire_break

    task automatic t_cold_junction;
        logic [31:0] w;
        int          src;
        tcs_fb_master_model_inst.exchange(3, 16'h0050, w);
        chk(w, 32'h0000_0000);
        for (src = 0; src < 4; src++) begin
            wrr(ca(3, O_CH_CONFIG), {29'h0, src[1:0], 1'b1});
            repeat (2) @(posedge clk);
            #1 chk({16'h0, cj_ref[3]}, (src[1:0] == CJ_EXTERNAL) ? 32'h50 : 32'h123);
        end
        $display("test cold junction done");
    endtask : t_cold_junction

    task automatic t_sets;
        wrr(A_SET_SELECT, 32'h0000_000E);
        rdc(A_SET_ACTIVE, 32'h0000_000F);
        pulse_restart();
        rdc(A_SET_ACTIVE, 32'h0000_000E);
        rdc(ca(0, O_CH_PROCESS), 32'h0000_0000);
        meas(0, 16'h0010, 1'b0, 1'b0);
        rdc(ca(1, O_CH_PROCESS), {16'd100, 16'h8000});
        wrr(A_SET_SELECT, 32'h0000_000F);
        pulse_restart();
        rdc(ca(0, O_CH_PROCESS), {16'd300, 16'h8010});
        // Frozen clock enable must swallow a new result
        @(posedge clk);
        ce <= 1'b0;
        meas(0, 16'h0020, 1'b0, 1'b0);
        ce <= 1'b1;
        rdc(ca(0, O_CH_PROCESS), {16'd300, 16'h8010});
        $display("test sets done");
    endtask : t_sets

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_limits();
        t_range();
        t_wire_break();
        t_cold_junction();
        t_sets();
        finish_test();
    end
endmodule : tb_tcs_channel_status

/* File: testbench/tcs_fb_master_model.sv */
`timescale 1ns/100ps
module tcs_fb_master_model
    import tcs_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic [DW-1:0] rdata_i,
    output logic      [AW-1:0] addr_o,
    output logic      [DW-1:0] wdata_o,
    output logic               wr_o,
    output logic               rd_o
);
    initial begin
        addr_o  = 8'h00;
        wdata_o = 32'h0000_0000;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    function automatic logic [AW-1:0] ch_addr(input int ch, input logic [3:0] off);
        return A_CH_BASE + A_CH_STRIDE * ch[7:0] + {4'h0, off};
    endfunction : ch_addr

    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        wdata_o <= ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        #1;
        d = rdata_i;
    endtask : rd_reg

    // One cyclic exchange: reference temperature out, status and value in
    task automatic exchange(input int ch, input logic [15:0] ext, output logic [DW-1:0] word);
        wr_reg(ch_addr(ch, O_CH_EXT_REF), {16'h0000, ext});
        rd_reg(ch_addr(ch, O_CH_PROCESS), word);
    endtask : exchange
endmodule : tcs_fb_master_model
